// ===== src/dtc_map.svh
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// byte offsets on the register bus
`define DTC_OFF_CTRL 6'h00
`define DTC_OFF_MODE 6'h04
`define DTC_OFF_TL0 6'h08
`define DTC_OFF_TH0 6'h0c
`define DTC_OFF_TL1 6'h10
`define DTC_OFF_TH1 6'h14
`define DTC_OFF_STAT 6'h18
`define DTC_OFF_EN 6'h1c
`define DTC_OFF_CLR 6'h20

// timer_control bit positions
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4
`define DTC_CTRL_IE1 3
`define DTC_CTRL_IT1 2
`define DTC_CTRL_IE0 1
`define DTC_CTRL_IT0 0

// timer_mode fields, per timer: gate, counter select, mode field
`define DTC_MODE_GATE1 7
`define DTC_MODE_CT1 6
`define DTC_MODE_M1_HI 5
`define DTC_MODE_M1_LO 4
`define DTC_MODE_GATE0 3
`define DTC_MODE_CT0 2
`define DTC_MODE_M0_HI 1
`define DTC_MODE_M0_LO 0

// event bits of status, enable, clear and vector acknowledge
`define DTC_EV_IE0 0
`define DTC_EV_TF0 1
`define DTC_EV_IE1 2
`define DTC_EV_TF1 3

`define DTC_RST_BYTE 8'h00
`define DTC_RST_EV 4'h0
`define DTC_PRESC_LAST 5'h1f

`endif

// ===== src/dtc_pkg.sv
package dtc_pkg;
    // order matches the two-bit mode field 00, 01, 10, 11
    typedef enum logic [1:0] {
        DTC_MODE_PRESC,
        DTC_MODE_16,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_e;
    typedef logic [7:0] dtc_byte_t;
endpackage

// ===== src/dtc_timer.sv
`include "dtc_map.svh"

module dtc_timer
    import dtc_pkg::*;
#(
    parameter bit SPLIT_HIGH = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire dtc_mode_e mode,
    input wire logic inc,
    input wire logic hi_inc,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire dtc_byte_t wdata,
    output dtc_byte_t lo_reg,
    output dtc_byte_t hi_reg,
    output logic ovf,
    output logic hi_ovf
);
    dtc_byte_t lo_next;
    dtc_byte_t hi_next;
    logic ovf_c;
    logic hi_ovf_c;

    always_comb begin
        lo_next = lo_reg;
        hi_next = hi_reg;
        ovf_c = 1'b0;
        hi_ovf_c = 1'b0;
        case (mode)
            DTC_MODE_PRESC: begin // [R12]
                if (inc) begin
                    if (lo_reg[4:0] == `DTC_PRESC_LAST) begin
                        lo_next[4:0] = 5'h00;
                        hi_next = hi_reg + 8'h01;
                        ovf_c = (hi_reg == 8'hff);
                    end else begin
                        lo_next[4:0] = lo_reg[4:0] + 5'h01;
                    end
                end
            end
            DTC_MODE_16: begin
                if (inc) begin // [R13] [R9]
                    {hi_next, lo_next} = {hi_reg, lo_reg} + 16'h0001;
                    ovf_c = ({hi_reg, lo_reg} == 16'hffff);
                end
            end
            DTC_MODE_RELOAD: begin
                if (inc) begin // [R14] [R17]
                    if (lo_reg == 8'hff) begin
                        lo_next = hi_reg;
                        ovf_c = 1'b1;
                    end else begin
                        lo_next = lo_reg + 8'h01;
                    end
                end
            end
            DTC_MODE_SPLIT: begin
                // timer 1 holds here; timer 0 splits into two byte counters
                if (SPLIT_HIGH) begin // [R16] [R12]
                    if (inc) begin
                        lo_next = lo_reg + 8'h01;
                        ovf_c = (lo_reg == 8'hff);
                    end
                    if (hi_inc) begin
                        hi_next = hi_reg + 8'h01;
                        hi_ovf_c = (hi_reg == 8'hff);
                    end
                end
            end
            default: begin
            end
        endcase
        // a software write wins over counting and cancels that overflow
        if (wr_lo) begin
            lo_next = wdata;
        end
        if (wr_hi) begin
            hi_next = wdata;
        end
        ovf = ovf_c & ~(wr_lo | wr_hi);
        hi_ovf = hi_ovf_c & ~wr_hi;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lo_reg <= `DTC_RST_BYTE;
            hi_reg <= `DTC_RST_BYTE;
        end else begin
            lo_reg <= lo_next;
            hi_reg <= hi_next;
        end
    end
endmodule

// ===== src/dtc_extirq.sv
`include "dtc_map.svh"

module dtc_extirq #(
    parameter bit BOTH_EDGES = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    input wire logic edge_mode,
    input wire logic ack,
    output logic flag_reg,
    output logic evt
);
    logic prev_reg;
    logic flag_next;
    logic edge_seen;

    always_comb begin
        edge_seen = BOTH_EDGES ? (pin != prev_reg) : (prev_reg & ~pin); // [R4] [R8]
        if (edge_mode) begin
            // a new edge in the acknowledge cycle is kept
            flag_next = edge_seen | (flag_reg & ~ack); // [R5] [R6]
            evt = edge_seen;
        end else begin
            // level mode: the flag follows the low input
            flag_next = ~pin; // [R7] [R8]
            evt = ~pin;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= 1'b1;
            flag_reg <= 1'b0;
        end else begin
            prev_reg <= pin;
            flag_reg <= flag_next;
        end
    end
endmodule

// ===== src/dtc_top.sv
// Contract
// R1: timer overflow sets its overflow flag; timer 1 overflow sets none while timer 0 is in mode 11
// R2: vectoring clears the timer overflow flag
// R3: timer counts only while run bit set
// R4: interrupt 1 edge flag on both edges
// R5: qualifying edge sets the edge flag
// R6: processed interrupt clears its edge flag
// R7: type bit picks edge or level, int 1
// R8: type bit picks falling edge or level, int 0
// R9: count is high byte over low byte
// R10: timer 1 gate bit qualifies counting
// R11: timer 1 selects clock or external events
// R12: mode 00 prescaled by 32; timer1 11 stops
// R13: mode 01 is a full 16-bit count
// R14: timer 1 mode 10 reloads from high byte
// R15: timer 0 has same gate and select
// R16: timer 0 mode 11 splits into two bytes
// R17: timer 0 mode 10 reloads from high byte
// R18: gated timer needs its interrupt input high
// R19: counter mode counts falling count-input edges
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`include "dtc_map.svh"

module dtc_top
    import dtc_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_int0,
    input wire logic ext_int1,
    input wire logic count_in0,
    input wire logic count_in1,
    input wire logic [3:0] vector_ack,
    output logic [3:0] int_req,
    output logic irq
);
    if (ADDR_W < 6) begin : g_addr_check
        $error("dtc_top: ADDR_W must be at least 6");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [5:0] off);
        hit = (addr == ADDR_W'(off));
    endfunction

    // bus slave state
    logic waitreq_reg;
    logic waitreq_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_en;

    // software control state
    logic tr0_reg;
    logic tr1_reg;
    logic it0_reg;
    logic it1_reg;
    dtc_byte_t mode_reg;
    logic tr0_next;
    logic tr1_next;
    logic it0_next;
    logic it1_next;
    dtc_byte_t mode_next;

    // flags and interrupt state
    logic tf0_reg;
    logic tf1_reg;
    logic tf0_next;
    logic tf1_next;
    logic [3:0] stat_reg;
    logic [3:0] stat_next;
    logic [3:0] en_reg;
    logic [3:0] en_next;
    logic irq_reg;
    logic irq_next;
    logic cnt_prev0_reg;
    logic cnt_prev1_reg;

    // timers and external inputs
    dtc_mode_e mode0;
    dtc_mode_e mode1;
    logic gate0;
    logic gate1;
    logic ct0;
    logic ct1;
    logic fall0;
    logic fall1;
    logic inc0;
    logic inc1;
    logic t0_ovf;
    logic t0_hi_ovf;
    logic t1_ovf;
    logic tf0_set;
    logic tf1_set;
    logic ie0;
    logic ie1;
    logic ie0_evt;
    logic ie1_evt;
    logic [3:0] events;
    dtc_byte_t lo0;
    dtc_byte_t hi0;
    dtc_byte_t lo1;
    dtc_byte_t hi1;
    logic wr_tl0;
    logic wr_th0;
    logic wr_tl1;
    logic wr_th1;

    // one wait state: data is ready in the cycle waitrequest drops
    always_comb begin
        wr_en = avs_write & ~waitreq_reg;
        waitreq_next = 1'b1;
        rdata_next = rdata_reg;
        if ((avs_read | avs_write) & waitreq_reg) begin
            waitreq_next = 1'b0;
            rdata_next = 32'h0000_0000;
            if (avs_read) begin
                if (hit(avs_address, `DTC_OFF_CTRL)) begin
                    rdata_next[7:0] = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, ie1, it1_reg, ie0, it0_reg};
                end else if (hit(avs_address, `DTC_OFF_MODE)) begin
                    rdata_next[7:0] = mode_reg;
                end else if (hit(avs_address, `DTC_OFF_TL0)) begin
                    rdata_next[7:0] = lo0;
                end else if (hit(avs_address, `DTC_OFF_TH0)) begin
                    rdata_next[7:0] = hi0;
                end else if (hit(avs_address, `DTC_OFF_TL1)) begin
                    rdata_next[7:0] = lo1;
                end else if (hit(avs_address, `DTC_OFF_TH1)) begin
                    rdata_next[7:0] = hi1;
                end else if (hit(avs_address, `DTC_OFF_STAT)) begin
                    rdata_next[3:0] = stat_reg;
                end else if (hit(avs_address, `DTC_OFF_EN)) begin
                    rdata_next[3:0] = en_reg;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitreq_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            waitreq_reg <= waitreq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest = waitreq_reg;
    assign avs_readdata = rdata_reg;

    // software writes to control and mode; flag bits are hardware-owned
    always_comb begin
        tr0_next = tr0_reg;
        tr1_next = tr1_reg;
        it0_next = it0_reg;
        it1_next = it1_reg;
        mode_next = mode_reg;
        if (wr_en && hit(avs_address, `DTC_OFF_CTRL)) begin
            tr1_next = avs_writedata[`DTC_CTRL_TR1];
            tr0_next = avs_writedata[`DTC_CTRL_TR0];
            it1_next = avs_writedata[`DTC_CTRL_IT1];
            it0_next = avs_writedata[`DTC_CTRL_IT0];
        end
        if (wr_en && hit(avs_address, `DTC_OFF_MODE)) begin
            mode_next = avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tr0_reg <= 1'b0;
            tr1_reg <= 1'b0;
            it0_reg <= 1'b0;
            it1_reg <= 1'b0;
            mode_reg <= `DTC_RST_BYTE;
        end else begin
            tr0_reg <= tr0_next;
            tr1_reg <= tr1_next;
            it0_reg <= it0_next;
            it1_reg <= it1_next;
            mode_reg <= mode_next;
        end
    end

    assign wr_tl0 = wr_en & hit(avs_address, `DTC_OFF_TL0);
    assign wr_th0 = wr_en & hit(avs_address, `DTC_OFF_TH0);
    assign wr_tl1 = wr_en & hit(avs_address, `DTC_OFF_TL1);
    assign wr_th1 = wr_en & hit(avs_address, `DTC_OFF_TH1);

    assign mode0 = dtc_mode_e'(mode_reg[`DTC_MODE_M0_HI:`DTC_MODE_M0_LO]);
    assign mode1 = dtc_mode_e'(mode_reg[`DTC_MODE_M1_HI:`DTC_MODE_M1_LO]);
    assign gate0 = mode_reg[`DTC_MODE_GATE0]; // [R15]
    assign gate1 = mode_reg[`DTC_MODE_GATE1]; // [R10]
    assign ct0 = mode_reg[`DTC_MODE_CT0]; // [R15]
    assign ct1 = mode_reg[`DTC_MODE_CT1]; // [R11]

    // count inputs are synchronous; one stage gives the falling edge
    assign fall0 = cnt_prev0_reg & ~count_in0; // [R19]
    assign fall1 = cnt_prev1_reg & ~count_in1; // [R19]
    assign inc0 = tr0_reg & (~gate0 | ext_int0) & (ct0 ? fall0 : 1'b1); // [R3] [R18]
    assign inc1 = tr1_reg & (~gate1 | ext_int1) & (ct1 ? fall1 : 1'b1); // [R3] [R18]

    dtc_timer #(
        .SPLIT_HIGH(1'b1)
    ) u_timer0 (
        .clk(clk),
        .rst_b(rst_b),
        .mode(mode0),
        .inc(inc0),
        .hi_inc(tr1_reg), // [R16]
        .wr_lo(wr_tl0),
        .wr_hi(wr_th0),
        .wdata(avs_writedata[7:0]),
        .lo_reg(lo0),
        .hi_reg(hi0),
        .ovf(t0_ovf),
        .hi_ovf(t0_hi_ovf)
    );

    dtc_timer #(
        .SPLIT_HIGH(1'b0)
    ) u_timer1 (
        .clk(clk),
        .rst_b(rst_b),
        .mode(mode1),
        .inc(inc1),
        .hi_inc(1'b0),
        .wr_lo(wr_tl1),
        .wr_hi(wr_th1),
        .wdata(avs_writedata[7:0]),
        .lo_reg(lo1),
        .hi_reg(hi1),
        .ovf(t1_ovf),
        .hi_ovf()
    );

    dtc_extirq #(
        .BOTH_EDGES(1'b0)
    ) u_extirq0 (
        .clk(clk),
        .rst_b(rst_b),
        .pin(ext_int0),
        .edge_mode(it0_reg),
        .ack(vector_ack[`DTC_EV_IE0]),
        .flag_reg(ie0),
        .evt(ie0_evt)
    );

    dtc_extirq #(
        .BOTH_EDGES(1'b1)
    ) u_extirq1 (
        .clk(clk),
        .rst_b(rst_b),
        .pin(ext_int1),
        .edge_mode(it1_reg),
        .ack(vector_ack[`DTC_EV_IE1]),
        .flag_reg(ie1),
        .evt(ie1_evt)
    );

    // split timer 0 borrows the timer 1 flag; timer 1 then sets none
    assign tf0_set = t0_ovf;
    assign tf1_set = (mode0 == DTC_MODE_SPLIT) ? t0_hi_ovf : t1_ovf; // [R16]
    assign events = {tf1_set, ie1_evt, tf0_set, ie0_evt};

    always_comb begin
        tf0_next = tf0_set | (tf0_reg & ~vector_ack[`DTC_EV_TF0]); // [R1] [R2]
        tf1_next = tf1_set | (tf1_reg & ~vector_ack[`DTC_EV_TF1]); // [R1] [R2]
        en_next = en_reg;
        if (wr_en && hit(avs_address, `DTC_OFF_EN)) begin
            en_next = avs_writedata[3:0];
        end
        stat_next = stat_reg;
        if (wr_en && hit(avs_address, `DTC_OFF_CLR)) begin
            stat_next = stat_reg & ~avs_writedata[3:0];
        end
        stat_next = stat_next | events;
        irq_next = |(stat_next & en_next);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tf0_reg <= 1'b0;
            tf1_reg <= 1'b0;
            stat_reg <= `DTC_RST_EV;
            en_reg <= `DTC_RST_EV;
            irq_reg <= 1'b0;
            cnt_prev0_reg <= 1'b1;
            cnt_prev1_reg <= 1'b1;
        end else begin
            tf0_reg <= tf0_next;
            tf1_reg <= tf1_next;
            stat_reg <= stat_next;
            en_reg <= en_next;
            irq_reg <= irq_next;
            cnt_prev0_reg <= count_in0;
            cnt_prev1_reg <= count_in1;
        end
    end

    assign irq = irq_reg;
    assign int_req = {tf1_reg, ie1, tf0_reg, ie0};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_tf0_set;
        t0_ovf |=> tf0_reg;
    endproperty
    a_tf0_set: assert property (p_tf0_set) else $error("tf0 not set on overflow"); // [R1]

    property p_tf1_clr;
        tf1_reg && vector_ack[`DTC_EV_TF1] && !tf1_set |=> !tf1_reg;
    endproperty
    a_tf1_clr: assert property (p_tf1_clr) else $error("tf1 not cleared on vector"); // [R2]

    property p_t1_hold;
        !tr1_reg && !wr_tl1 && !wr_th1 |=> $stable(lo1) && $stable(hi1);
    endproperty
    a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved while off"); // [R3]

    property p_ie1_both;
        it1_reg && (ext_int1 != $past(ext_int1)) |=> ie1;
    endproperty
    a_ie1_both: assert property (p_ie1_both) else $error("ie1 missed an edge"); // [R4]

    property p_ie0_fall;
        it0_reg && $fell(ext_int0) |=> ie0;
    endproperty
    a_ie0_fall: assert property (p_ie0_fall) else $error("ie0 missed falling edge"); // [R5]

    property p_ie0_ack;
        it0_reg && it0_next && ie0 && vector_ack[`DTC_EV_IE0] && !ie0_evt |=> !ie0;
    endproperty
    a_ie0_ack: assert property (p_ie0_ack) else $error("ie0 not cleared on ack"); // [R6]

    property p_ie1_level;
        !it1_reg && !it1_next && !ext_int1 ##1 !ext_int1 |-> ie1;
    endproperty
    a_ie1_level: assert property (p_ie1_level) else $error("ie1 not following low level"); // [R7]

    property p_t1_stop;
        mode1 == DTC_MODE_SPLIT && !wr_tl1 && !wr_th1 |=> $stable(lo1) && $stable(hi1);
    endproperty
    a_t1_stop: assert property (p_t1_stop) else $error("timer 1 moved in mode 11"); // [R12]

    property p_t1_reload;
        mode1 == DTC_MODE_RELOAD && inc1 && lo1 == 8'hff && !wr_tl1 && !wr_th1 |=> lo1 == $past(hi1) && tf1_reg;
    endproperty
    a_t1_reload: assert property (p_t1_reload) else $error("timer 1 reload wrong"); // [R14]

    property p_t0_gate;
        gate0 && !ext_int0 && !wr_tl0 && mode0 != DTC_MODE_PRESC |=> $stable(lo0);
    endproperty
    a_t0_gate: assert property (p_t0_gate) else $error("gated timer 0 counted"); // [R18]

    property p_t1_event;
        ct1 && tr1_reg && !gate1 && mode1 == DTC_MODE_16 && fall1 && lo1 != 8'hff && !wr_tl1 && !wr_th1
            |=> lo1 == $past(lo1) + 8'h01;
    endproperty
    a_t1_event: assert property (p_t1_event) else $error("timer 1 missed count edge"); // [R19]

    property p_bus_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one wait state");

    property p_cov_tf1_split;
        mode0 == DTC_MODE_SPLIT && t0_hi_ovf ##1 tf1_reg;
    endproperty
    c_tf1_split: cover property (p_cov_tf1_split);

    property p_cov_irq;
        !irq ##1 irq;
    endproperty
    c_irq: cover property (p_cov_irq);

    property p_cov_ie1;
        !ie1 ##1 ie1;
    endproperty
    c_ie1: cover property (p_cov_ie1);
endmodule

// ===== tb/dtc_pins_model.sv
module dtc_pins_model (
    input wire logic clk,
    output logic ext_int0,
    output logic ext_int1,
    output logic count_in0,
    output logic count_in1
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ext_int0 = 1'h1;
        ext_int1 = 1'h1;
        count_in0 = 1'h1;
        count_in1 = 1'h1;
    end

    // each level held two clocks so a sampling stage never misses a falling edge
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            if (ch == 0) count_in0 <= 1'h0; else count_in1 <= 1'h0;
            repeat (2) @(posedge clk);
            if (ch == 0) count_in0 <= 1'h1; else count_in1 <= 1'h1;
            repeat (2) @(posedge clk);
        end
    endtask

    // settle time lets the flag and irq registers follow the pin
    task automatic set_int(input int ch, input logic v);
        if (ch == 0) ext_int0 <= v; else ext_int1 <= v;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ===== tb/tb_top.sv
`include "dtc_map.svh"

module tb_top
    import dtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic ch;
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic ext;
        logic [7:0] tl;
        logic [7:0] th;
        logic [7:0] n;
        logic [7:0] etl;
        logic [7:0] eth;
        logic [7:0] tlm;
        logic [3:0] ereq;
    } dtc_row_s;

    logic clk;
    logic rst_b;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_int0;
    logic ext_int1;
    logic count_in0;
    logic count_in1;
    logic [3:0] vector_ack;
    logic [3:0] int_req;
    logic irq;
    logic [31:0] q;
    logic [31:0] t;
    dtc_row_s r;
    int err_count;
    int comparisons;

    dtc_row_s rows [11] = '{
        '{1'h0, 8'h05, 8'h15, 1'h1, 8'hfe, 8'hff, 8'h03, 8'h01, 8'h00, 8'hff, 4'h2},
        '{1'h1, 8'h50, 8'h45, 1'h1, 8'hfe, 8'h12, 8'h02, 8'h00, 8'h13, 8'hff, 4'h0},
        '{1'h0, 8'h06, 8'h15, 1'h1, 8'hfe, 8'h80, 8'h03, 8'h81, 8'h80, 8'hff, 4'h2},
        '{1'h1, 8'h60, 8'h45, 1'h1, 8'hff, 8'hf0, 8'h02, 8'hf1, 8'hf0, 8'hff, 4'h8},
        '{1'h1, 8'h40, 8'h45, 1'h1, 8'h00, 8'h05, 8'h21, 8'h01, 8'h06, 8'h1f, 4'h0},
        '{1'h1, 8'h70, 8'h45, 1'h1, 8'h12, 8'h34, 8'h05, 8'h12, 8'h34, 8'hff, 4'h0},
        '{1'h1, 8'hd0, 8'h45, 1'h0, 8'h10, 8'h00, 8'h04, 8'h10, 8'h00, 8'hff, 4'h0},
        '{1'h1, 8'hd0, 8'h45, 1'h1, 8'h10, 8'h00, 8'h04, 8'h14, 8'h00, 8'hff, 4'h0},
        '{1'h0, 8'h0d, 8'h15, 1'h0, 8'h10, 8'h00, 8'h04, 8'h10, 8'h00, 8'hff, 4'h0},
        '{1'h0, 8'h05, 8'h05, 1'h1, 8'h10, 8'h00, 8'h04, 8'h10, 8'h00, 8'hff, 4'h0},
        '{1'h0, 8'h07, 8'h15, 1'h1, 8'hfe, 8'h33, 8'h03, 8'h01, 8'h33, 8'hff, 4'h2}
    };

    dtc_top dut (
        .clk(clk),
        .rst_b(rst_b),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .ext_int0(ext_int0),
        .ext_int1(ext_int1),
        .count_in0(count_in0),
        .count_in1(count_in1),
        .vector_ack(vector_ack),
        .int_req(int_req),
        .irq(irq)
    );

    dtc_pins_model pins (
        .clk(clk),
        .ext_int0(ext_int0),
        .ext_int1(ext_int1),
        .count_in0(count_in0),
        .count_in1(count_in1)
    );

    always #5 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic chkb(input string name, input logic exp, input logic got);
        chk(name, 32'(exp), 32'(got));
    endtask

    // one idle cycle after release so back-to-back calls never reassign a strobe in one step
    task automatic bus(input logic wr_n_rd, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr_n_rd;
        avs_read <= !wr_n_rd;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0) begin
            n++;
            if (n > 20) begin
                err_count++;
                report_and_stop();
            end
            @(posedge clk);
        end
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
    endtask

    task automatic rd(input logic [5:0] a);
        bus(1'h0, a, 8'h00);
    endtask

    task automatic ack(input logic [3:0] m);
        vector_ack <= m;
        @(posedge clk);
        vector_ack <= 4'h0;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        clk = 1'h0;
        rst_b = 1'h0;
        avs_address = 6'h00;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0000_0000;
        vector_ack = 4'h0;
        err_count = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        chkb("wait_in_reset", 1'h1, avs_waitrequest);
        chkb("irq_in_reset", 1'h0, irq);
        rst_b <= 1'h1;
        @(posedge clk);
        // 0x24 is past the map and must read zero
        for (int a = 0; a <= 36; a += 4) begin
            rd(6'(a));
            chk("reset_value", 32'h0000_0000, q);
        end
        wr(6'h24, 8'hff);
        rd(6'h24);
        chk("unmapped", 32'h0000_0000, q);

        for (int i = 0; i < 11; i++) begin
            r = rows[i];
            wr(`DTC_OFF_CTRL, 8'h05);
            pins.set_int(0, r.ext);
            pins.set_int(1, r.ext);
            wr(`DTC_OFF_MODE, r.mode);
            wr(r.ch ? `DTC_OFF_TL1 : `DTC_OFF_TL0, r.tl);
            wr(r.ch ? `DTC_OFF_TH1 : `DTC_OFF_TH0, r.th);
            ack(4'hf);
            wr(`DTC_OFF_CTRL, r.ctrl);
            pins.pulse(r.ch, r.n);
            repeat (4) @(posedge clk);
            wr(`DTC_OFF_CTRL, 8'h05);
            rd(r.ch ? `DTC_OFF_TL1 : `DTC_OFF_TL0);
            chk("count_low", {24'h00_0000, r.etl}, q & {24'h00_0000, r.tlm});
            rd(r.ch ? `DTC_OFF_TH1 : `DTC_OFF_TH0);
            chk("count_high", {24'h00_0000, r.eth}, q);
            chk("ovf_flags", {28'h000_0000, r.ereq}, {28'h000_0000, int_req & 4'ha});
        end

        ack(4'h2);
        chkb("tf0_vector", 1'h0, int_req[1]);

        wr(`DTC_OFF_MODE, 8'h01);
        wr(`DTC_OFF_TL0, 8'h00);
        wr(`DTC_OFF_TH0, 8'h00);
        wr(`DTC_OFF_CTRL, 8'h15);
        repeat (20) @(posedge clk);
        wr(`DTC_OFF_CTRL, 8'h05);
        rd(`DTC_OFF_TL0);
        t = q;
        repeat (10) @(posedge clk);
        rd(`DTC_OFF_TL0);
        chk("halt_keeps", t, q);
        chkb("clock_counts", 1'h1, t >= 32'h0000_0014);

        ack(4'hf);
        wr(`DTC_OFF_CLR, 8'h0f);
        wr(`DTC_OFF_EN, 8'h04);
        pins.set_int(1, 1'h0);
        chkb("ie1_fall", 1'h1, int_req[2]);
        chkb("irq_on", 1'h1, irq);
        wr(`DTC_OFF_EN, 8'h00);
        chkb("irq_masked", 1'h0, irq);
        wr(`DTC_OFF_EN, 8'h04);
        chkb("irq_unmasked", 1'h1, irq);
        wr(`DTC_OFF_CLR, 8'h04);
        chkb("irq_cleared", 1'h0, irq);
        rd(`DTC_OFF_STAT);
        chk("status_cleared", 32'h0000_0000, q & 32'h0000_0004);
        ack(4'h4);
        chkb("ie1_processed", 1'h0, int_req[2]);
        pins.set_int(1, 1'h1);
        chkb("ie1_rise", 1'h1, int_req[2]);
        ack(4'h4);
        pins.set_int(0, 1'h0);
        chkb("ie0_fall", 1'h1, int_req[0]);
        ack(4'h1);
        pins.set_int(0, 1'h1);
        chkb("ie0_rise_ignored", 1'h0, int_req[0]);

        wr(`DTC_OFF_CTRL, 8'h00);
        pins.set_int(0, 1'h0);
        chkb("ie0_level_low", 1'h1, int_req[0]);
        pins.set_int(0, 1'h1);
        chkb("ie0_level_high", 1'h0, int_req[0]);
        pins.set_int(1, 1'h0);
        chkb("ie1_level_low", 1'h1, int_req[2]);
        pins.set_int(1, 1'h1);
        chkb("ie1_level_high", 1'h0, int_req[2]);

        // split timer 0: high byte runs on the timer 1 run bit and borrows its flag
        wr(`DTC_OFF_MODE, 8'h03);
        wr(`DTC_OFF_TH0, 8'hfe);
        wr(`DTC_OFF_TL0, 8'h00);
        ack(4'hf);
        wr(`DTC_OFF_CTRL, 8'h40);
        repeat (4) @(posedge clk);
        wr(`DTC_OFF_CTRL, 8'h00);
        chkb("split_tf1", 1'h1, int_req[3]);
        rd(`DTC_OFF_TL0);
        chk("split_tl0_idle", 32'h0000_0000, q);

        // reset in mid-run must drop flags, irq and the bus answer
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        chk("int_req_mid_reset", 32'h0000_0000, 32'(int_req));
        chkb("irq_mid_reset", 1'h0, irq);
        chkb("wait_mid_reset", 1'h1, avs_waitrequest);
        rst_b <= 1'h1;
        @(posedge clk);
        rd(`DTC_OFF_EN);
        chk("en_after_reset", 32'h0000_0000, q);
        rd(`DTC_OFF_TH0);
        chk("th0_after_reset", 32'h0000_0000, q);
        report_and_stop();
    end
endmodule
